// File: hw/fstc_pkg.sv
/*
 * Constants, types and register map of the frame start trigger control.
 * Assumes one clock pclk at 10 MHz and an APB master with 32-bit data.
 */
//
// Summary of operation
// - Works only in standard mode; reset selects legacy mode, block stays idle.
// - While waiting for frame start, each accepted trigger starts one frame.
// - Waiting begins after start command, and after start trigger if enabled.
// - Frame trigger mode is off or on, selecting internal or outside triggers.
// - With trigger mode off every frame trigger is made internally.
// - Mode off, single frame: one internal trigger per start command.
// - Mode off, continuous: internal triggers from start command until stop command.
// - Rate limit disabled: internal triggers at the fastest permitted rate.
// - Rate limit enabled: programmed period, but never faster than permitted.
// - Triggers count only while waiting for frame start; otherwise ignored.
// - With trigger mode off exposure lasts the programmed exposure time.
// - Triggers arriving when not ready are dropped; outside must pace them.
// - Software origin: soft trigger command with frame start selected triggers.
// - Line origin: the trigger comes from the hardware trigger input pin.
// - Polarity select chooses rising or falling edge of the line input.
// - After reset the trigger origin is the line input.
// - Mode on with software origin: exposure is the programmed time.
// - Mode on with line origin: programmed time or trigger pulse width.
// - Accepting a trigger leaves waiting; waiting resumes when ready again.
// - Timed exposure: line trigger during exposure dropped, overtrigger flagged.
// - Width exposure runs from active edge to the following opposite edge.
`default_nettype none
package fstc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_EXPO = 8'h04;
    localparam logic [7:0] OFS_PER  = 8'h08;
    localparam logic [7:0] OFS_CMD  = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;

    // Command bits (write only, self clearing)
    localparam int CMD_START = 0;
    localparam int CMD_STOP  = 1;
    localparam int CMD_SOFT  = 2;

    // Status bits; bits 2:0 hold the state code
    localparam int STAT_OVR  = 3;
    localparam int STAT_EXP  = 4;
    localparam int STAT_WAIT = 5;
    localparam int STAT_LINE = 6;

    typedef struct packed {
        logic acq_trig;   // 8 acquisition start trigger on
        logic sel_frame;  // 7 soft trigger targets frame start
        logic rate_en;    // 6 frame_rate_limit_enable
        logic width_exp;  // 5 trigger width exposure
        logic falling;    // 4 falling edge active
        logic src_line;   // 3 origin is line input
        logic cont;       // 2 continuous capture
        logic trig_mode;  // 1 frame trigger mode on
        logic std;        // 0 standard mode
    } fstc_ctrl_t;

    localparam fstc_ctrl_t CTRL_RST = 9'h088;
    localparam logic [31:0] EXPO_RST = 32'h0000_0064;
    localparam logic [31:0] PER_RST  = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_WAIT_AST = 3'h1,
        ST_WAIT_FST = 3'h3,
        ST_EXPOSE   = 3'h2,
        ST_RECOVER  = 3'h6
    } fstc_state_t;

    typedef struct packed {
        logic frame_start; // one-cycle pulse
        logic expose;      // exposure in progress
        logic waiting;     // waiting for frame start
        logic overtrig;    // one-cycle pulse
    } fstc_evt_t;

    typedef struct packed {
        fstc_state_t st;
        fstc_ctrl_t  ctrl;
        logic [31:0] expo;
        logic [31:0] per;
        logic [31:0] cnt_exp;
        logic [31:0] cnt_per;
        logic [2:0]  sync;
        logic        lvl;
        logic        lvl_d;
        logic        ovr;
        fstc_evt_t   evt;
        logic [31:0] rdata;
        logic        slverr;
    } fstc_core_t;

endpackage
`default_nettype wire

// File: hw/fstc_top.sv
/*
 * Frame start trigger control with APB register slave.
 * Assumes acq_start_trig and min_frame_period come from logic on pclk;
 * the hardware trigger pin is asynchronous.
 */
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module fstc_top
    import fstc_pkg::*;
(
    input  wire logic        pclk,                    // Clock, 10 MHz
    input  wire logic        presetn,                 // Async reset, low
    input  wire logic        psel,                    // APB select
    input  wire logic        penable,                 // APB enable
    input  wire logic        pwrite,                  // APB write
    input  wire logic [7:0]  paddr,                   // APB address
    input  wire logic [31:0] pwdata,                  // APB write data
    output logic      [31:0] prdata,                  // APB read data
    output logic             pready,                  // APB ready
    output logic             pslverr,                 // APB error
    input  wire logic        hw_frame_trigger_signal, // Line 1 pin
    input  wire logic        acq_start_trig,          // Acq start pulse
    input  wire logic [31:0] min_frame_period,        // Fastest period
    output fstc_evt_t        evt                      // Frame events
);

    fstc_core_t r;
    fstc_core_t n;

    logic        setup;
    logic        wr;
    logic        cmd_start;
    logic        cmd_stop;
    logic        cmd_soft;
    logic        act_edge;
    logic        end_edge;
    logic        hw_mode;
    logic        width_mode;
    logic        hw_timed;
    logic [31:0] per_eff;
    logic        int_fire;
    logic        trig_fire;
    logic        exp_done;

    //--------------------------------------------------------------
    // Bus decode
    //--------------------------------------------------------------
    assign setup = psel & ~penable;
    assign wr    = psel & penable & pwrite;
    assign pready  = psel & penable;
    assign prdata  = r.rdata;
    assign pslverr = r.slverr & psel & penable;

    assign cmd_start = wr && paddr == OFS_CMD
                       && pwdata[CMD_START] && r.ctrl.std;
    assign cmd_stop  = wr && paddr == OFS_CMD && pwdata[CMD_STOP];
    // Soft trigger only when frame start is the selected target
    assign cmd_soft  = wr && paddr == OFS_CMD && pwdata[CMD_SOFT]
                       && r.ctrl.sel_frame;

    //--------------------------------------------------------------
    // Trigger sources
    //--------------------------------------------------------------
    // Edge of the filtered line level, chosen by polarity
    assign act_edge = r.ctrl.falling ? (~r.lvl & r.lvl_d)
                                     : (r.lvl & ~r.lvl_d);
    assign end_edge = r.ctrl.falling ? (r.lvl & ~r.lvl_d)
                                     : (~r.lvl & r.lvl_d);

    assign hw_mode    = r.ctrl.trig_mode & r.ctrl.src_line;
    assign width_mode = hw_mode & r.ctrl.width_exp;
    assign hw_timed   = hw_mode & ~r.ctrl.width_exp;

    // Programmed period used only if slower than the fastest allowed
    assign per_eff = (r.ctrl.rate_en && r.per > min_frame_period)
                     ? r.per : min_frame_period;
    assign int_fire = r.cnt_per >= per_eff;

    // Mode selects internal or outside triggers
    assign trig_fire = r.ctrl.trig_mode
                       ? (r.ctrl.src_line ? act_edge : cmd_soft)
                       : int_fire;

    // Timed exposure lasts expo cycles, at least one
    assign exp_done = width_mode ? end_edge
                      : (r.cnt_exp + 32'h1 >= r.expo);

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb begin
        n = r;
        n.evt.frame_start = 1'b0;
        n.evt.overtrig    = 1'b0;

        // Three-stage synchroniser, level taken once stages 2 and 3 agree
        n.sync = {r.sync[1:0], hw_frame_trigger_signal};
        if (r.sync[1] == r.sync[2]) begin
            n.lvl = r.sync[2];
        end
        n.lvl_d = r.lvl;

        if (r.cnt_per != 32'hFFFF_FFFF) begin
            n.cnt_per = r.cnt_per + 32'h1;
        end

        // Register writes
        if (wr) begin
            unique case (paddr)
                OFS_CTRL: n.ctrl = fstc_ctrl_t'(pwdata[8:0]);
                OFS_EXPO: n.expo = pwdata;
                OFS_PER:  n.per  = pwdata;
                OFS_STAT: begin
                    if (pwdata[STAT_OVR]) begin
                        n.ovr = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Acquisition sequence
        unique case (r.st)
            ST_IDLE: begin
                if (cmd_start) begin
                    n.st = r.ctrl.acq_trig ? ST_WAIT_AST
                                           : ST_WAIT_FST;
                end
            end
            ST_WAIT_AST: begin
                if (acq_start_trig) begin
                    n.st = ST_WAIT_FST;
                end
            end
            ST_WAIT_FST: begin
                // Only state in which a trigger is accepted
                if (trig_fire) begin
                    n.st = ST_EXPOSE;
                    n.evt.frame_start = 1'b1;
                    n.cnt_exp = 32'h0;
                    // Frame start cycle counts as one, so starts land one period apart
                    n.cnt_per = 32'h1;
                end
            end
            ST_EXPOSE: begin
                n.cnt_exp = r.cnt_exp + 32'h1;
                if (hw_timed && act_edge) begin
                    n.evt.overtrig = 1'b1;
                end
                if (exp_done) begin
                    // Single frame ends the acquisition after one frame
                    n.st = r.ctrl.cont ? ST_RECOVER
                                       : ST_IDLE;
                end
            end
            ST_RECOVER: begin
                // Triggers here are dropped; looks one cycle ahead so that waiting
                // resumes in time for a start exactly one fastest period later
                if (n.cnt_per >= min_frame_period) begin
                    n.st = ST_WAIT_FST;
                end
            end
            default: n.st = ST_IDLE;
        endcase

        if (cmd_stop || !r.ctrl.std) begin
            n.st = ST_IDLE;
            // A trigger in the stop cycle is dropped as well
            n.evt.frame_start = 1'b0;
        end

        // Set wins over clear
        if (n.evt.overtrig) begin
            n.ovr = 1'b1;
        end

        n.evt.expose  = n.st == ST_EXPOSE;
        n.evt.waiting = n.st == ST_WAIT_FST;

        // Read data captured in the setup phase
        if (setup) begin
            n.slverr = 1'b0;
            unique case (paddr)
                OFS_CTRL: n.rdata = {23'h0, r.ctrl};
                OFS_EXPO: n.rdata = r.expo;
                OFS_PER:  n.rdata = r.per;
                OFS_CMD:  n.rdata = 32'h0;
                OFS_STAT: n.rdata = {25'h0, r.lvl, r.evt.waiting,
                                     r.evt.expose, r.ovr, r.st};
                default: begin
                    n.rdata  = 32'h0;
                    n.slverr = 1'b1;
                end
            endcase
        end
    end

    //--------------------------------------------------------------
    // State register
    //--------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.st      <= ST_IDLE;
            r.ctrl    <= CTRL_RST;
            r.expo    <= EXPO_RST;
            r.per     <= PER_RST;
            r.cnt_exp <= 32'h0;
            r.cnt_per <= 32'hFFFF_FFFF;
            r.sync    <= 3'h0;
            r.lvl     <= 1'b0;
            r.lvl_d   <= 1'b0;
            r.ovr     <= 1'b0;
            r.evt     <= 4'h0;
            r.rdata   <= 32'h0;
            r.slverr  <= 1'b0;
        end else begin
            r <= n;
        end
    end

    assign evt = r.evt;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_fs_in_wait: assert property (
        r.evt.frame_start |-> $past(r.st) == ST_WAIT_FST)
        else $error("frame start outside waiting state");

    chk_fs_expose: assert property (
        r.evt.frame_start |-> r.st == ST_EXPOSE && r.cnt_exp == 32'h0
                              && !r.evt.waiting)
        else $error("frame start did not begin exposure");

    chk_legacy_idle: assert property (
        !r.ctrl.std |=> r.st == ST_IDLE)
        else $error("legacy mode left idle");

    chk_stop_idle: assert property (
        cmd_stop |=> r.st == ST_IDLE && !r.evt.frame_start)
        else $error("stop command ignored");

    chk_start_wait: assert property (
        r.st == ST_IDLE && cmd_start && !r.ctrl.acq_trig && !cmd_stop
        |=> r.st == ST_WAIT_FST)
        else $error("start command did not arm");

    chk_ovt_cause: assert property (
        r.evt.overtrig |-> $past(r.st) == ST_EXPOSE && $past(hw_timed) && $past(act_edge)
                           && r.ovr)
        else $error("overtrigger without cause");

    chk_timed_end: assert property (
        r.st == ST_EXPOSE && !width_mode && exp_done
        |=> r.st != ST_EXPOSE)
        else $error("timed exposure overran");

    chk_width_end: assert property (
        r.st == ST_EXPOSE && width_mode && !end_edge && r.ctrl.std
        && !cmd_stop |=> r.st == ST_EXPOSE)
        else $error("width exposure ended early");

    chk_single_idle: assert property (
        r.st == ST_EXPOSE && exp_done && !r.ctrl.cont
        |=> r.st == ST_IDLE && !r.evt.expose && !r.evt.waiting)
        else $error("single frame did not stop");

    chk_edge_once: assert property (
        act_edge |=> !act_edge)
        else $error("edge pulse longer than one cycle");

    //--------------------------------------------------------------
    // Checks on trigger acceptance
    //--------------------------------------------------------------
    chk_soft_accept: assert property (
        r.st == ST_WAIT_FST && r.ctrl.trig_mode && !r.ctrl.src_line && cmd_soft
        && r.ctrl.std && !cmd_stop |=> r.evt.frame_start)
        else $error("soft trigger not taken");

    chk_line_accept: assert property (
        r.st == ST_WAIT_FST && hw_mode && act_edge && r.ctrl.std && !cmd_stop
        |=> r.evt.frame_start && r.evt.expose)
        else $error("line edge not taken");

    chk_line_only: assert property (
        r.st == ST_WAIT_FST && hw_mode && !act_edge |=> !r.evt.frame_start)
        else $error("frame start without line edge");

    chk_off_fire: assert property (
        r.st == ST_WAIT_FST && !r.ctrl.trig_mode && r.ctrl.std && !cmd_stop
        && r.cnt_per >= min_frame_period && (!r.ctrl.rate_en || r.cnt_per >= r.per)
        |=> r.evt.frame_start)
        else $error("internal trigger missing");

    chk_rate_floor: assert property (
        r.st == ST_WAIT_FST && !r.ctrl.trig_mode && r.cnt_per < min_frame_period
        |=> !r.evt.frame_start)
        else $error("internal trigger too fast");

    chk_rate_prog: assert property (
        r.st == ST_WAIT_FST && !r.ctrl.trig_mode && r.ctrl.rate_en && r.cnt_per < r.per
        |=> !r.evt.frame_start)
        else $error("programmed period not kept");

    chk_busy_quiet: assert property (
        r.st != ST_WAIT_FST |=> !r.evt.frame_start)
        else $error("trigger taken while not waiting");

    chk_fs_pulse: assert property (
        r.evt.frame_start |=> !r.evt.frame_start)
        else $error("frame start longer than one cycle");

    chk_status_flags: assert property (
        r.evt.waiting == (r.st == ST_WAIT_FST) && r.evt.expose == (r.st == ST_EXPOSE))
        else $error("status flags disagree with state");

    chk_recover_min: assert property (
        $past(r.st) == ST_RECOVER && r.st == ST_WAIT_FST |-> r.cnt_per >= min_frame_period)
        else $error("waiting resumed too early");

    //--------------------------------------------------------------
    // Checks on acquisition sequence and status
    //--------------------------------------------------------------
    chk_legacy_quiet: assert property (
        !r.ctrl.std |=> !r.evt.frame_start && !r.evt.expose)
        else $error("legacy mode produced a frame");

    chk_ast_hold: assert property (
        r.st == ST_WAIT_AST && !acq_start_trig |=> r.st != ST_WAIT_FST)
        else $error("waiting without start trigger");

    chk_ast_go: assert property (
        r.st == ST_WAIT_AST && acq_start_trig && r.ctrl.std && !cmd_stop
        |=> r.st == ST_WAIT_FST)
        else $error("start trigger not taken");

    chk_single_once: assert property (
        r.st == ST_EXPOSE && exp_done && !r.ctrl.cont
        |=> !r.evt.waiting ##1 !r.evt.frame_start)
        else $error("single frame repeated");

    chk_cont_recover: assert property (
        r.st == ST_EXPOSE && exp_done && r.ctrl.cont && r.ctrl.std && !cmd_stop
        |=> r.st == ST_RECOVER)
        else $error("continuous capture stopped");

    chk_soft_timed: assert property (
        r.st == ST_EXPOSE && r.ctrl.trig_mode && !r.ctrl.src_line && r.cnt_exp + 32'h1 < r.expo
        && r.ctrl.std && !cmd_stop |=> r.st == ST_EXPOSE)
        else $error("soft exposure cut short");

    chk_ovr_sticky: assert property (
        r.ovr && !(wr && paddr == OFS_STAT && pwdata[STAT_OVR]) |=> r.ovr)
        else $error("overtrigger flag lost");

    chk_ovr_clear: assert property (
        r.ovr && wr && paddr == OFS_STAT && pwdata[STAT_OVR]
        && !(r.st == ST_EXPOSE && hw_timed && act_edge) |=> !r.ovr)
        else $error("overtrigger flag not cleared");

    //--------------------------------------------------------------
    // Scenario covers
    //--------------------------------------------------------------
    cov_soft: cover property (cmd_soft && r.st == ST_WAIT_FST);
    cov_frame: cover property (r.evt.frame_start);
    cov_overtrig: cover property (r.evt.overtrig);
    cov_recover: cover property (r.st == ST_RECOVER ##1 r.st == ST_WAIT_FST);
    cov_width: cover property (width_mode && r.st == ST_EXPOSE && end_edge);

endmodule

`default_nettype wire

// File: testbench/fstc_trig_src.sv
/*
 * Outside trigger source model driving the line 1 trigger pin.
 * Assumes the bench asks for pin levels on pclk; the pin moves off the clock grid.
 */
`timescale 1ns/100ps
`default_nettype none

module fstc_trig_src (
    input  wire logic level_req, // Wanted pin level
    output logic      pin        // Line 1 trigger pin
);
    initial pin = 1'b0;
    // Asynchronous to pclk, as a real outside source would be
    always @(level_req) pin <= #37 level_req;
endmodule

`default_nettype wire

// File: testbench/frame_start_trigger_control_tb.sv
/*
 * Self-checking bench of the frame start trigger control.
 * Assumes fstc_top and fstc_pkg; drives APB, the trigger pin and the start trigger.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s exp %0h got %0h", n, e, g); end end

module frame_start_trigger_control_tb;
    import fstc_pkg::*;

    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        lreq = 0, ast = 0, se, pready, pslverr, line;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, mfp = 10, q, prdata;
    fstc_evt_t   evt;
    int          err_total = 0, comparisons = 0, nfs = 0, cyc = 0, last = 0, prev = 0;
    int          elen = 0, ecur = 0, seed = 42756, n0, p, m, novt = 0;

    always #50 pclk = ~pclk;

    fstc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hw_frame_trigger_signal(line),
        .acq_start_trig(ast), .min_frame_period(mfp), .evt(evt));

    fstc_trig_src src (.level_req(lreq), .pin(line));

    // Frame start count, spacing and exposure length
    always @(posedge pclk) begin
        cyc++;
        if (evt.frame_start === 1'b1) begin
            nfs++;
            prev = last;
            last = cyc;
        end
        if (evt.overtrig === 1'b1) novt++;
        if (evt.expose === 1'b1) ecur++;
        else if (ecur != 0) begin
            elen = ecur;
            ecur = 0;
        end
    end

    task automatic test_done();
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        q = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin
            err_total++;
            $display("Error apb pready exp 1 got %0b", pready);
            test_done();
        end
    endtask

    task automatic wfs(input int t);
        int k;
        k = 0;
        while (nfs < t && k < 400) begin
            @(posedge pclk);
            k++;
        end
        if (nfs < t) begin
            err_total++;
            $display("Error frame count exp %0d got %0d", t, nfs);
            test_done();
        end
    endtask

    function automatic int eper(input logic en, input int per, input int mn);
        return (en && per > mn) ? per : mn;
    endfunction

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, OFS_CTRL, 0);
        `CHK("ctrl", 32'h0000_0088, q)
        apb(0, OFS_EXPO, 0);
        `CHK("expo", EXPO_RST, q)
        apb(0, OFS_PER, 0);
        `CHK("per", PER_RST, q)
        apb(0, 8'h14, 0);
        `CHK("unmapped", 33'h1_0000_0000, {se, q})
        apb(1, OFS_CMD, 1);
        repeat (20) @(posedge pclk);
        `CHK("legacy", 0, nfs)
        apb(1, OFS_EXPO, 3);
        apb(1, OFS_CTRL, 1);
        apb(1, OFS_CMD, 1);
        wfs(1);
        repeat (30) @(posedge pclk);
        `CHK("single", 1, nfs)
        `CHK("exp len", 3, elen)
        for (int i = 0; i < 4; i++) begin
            m = 8 + ($unsigned($random(seed)) % 13);
            p = (i == 1) ? m - 1 : (i == 3) ? m : m + 1 + ($unsigned($random(seed)) % 20);
            mfp <= m;
            apb(1, OFS_PER, p);
            apb(1, OFS_CTRL, (i != 0) ? 32'h45 : 32'h05);
            apb(1, OFS_CMD, 1);
            wfs(nfs + 3);
            `CHK("period", eper(i != 0, p, m), last - prev)
            apb(1, OFS_CMD, 2);
            repeat (2) @(posedge pclk);
            n0 = nfs;
            repeat (60) @(posedge pclk);
            `CHK("stop", n0, nfs)
        end
        apb(1, OFS_EXPO, 40);
        apb(1, OFS_CTRL, 32'h83);
        n0 = nfs;
        apb(1, OFS_CMD, 4);
        repeat (5) @(posedge pclk);
        `CHK("idle soft", n0, nfs)
        apb(1, OFS_CMD, 1);
        apb(1, OFS_CMD, 4);
        @(posedge pclk);
        `CHK("soft", 1'b1, evt.frame_start)
        apb(1, OFS_CMD, 4);
        `CHK("busy", 1'b0, evt.waiting)
        repeat (50) @(posedge pclk);
        `CHK("drop", n0 + 1, nfs)
        `CHK("soft len", 40, elen)
        for (int f = 0; f < 2; f++) begin
            lreq <= f[0];
            apb(1, OFS_CTRL, 32'h0B | (f << 4));
            repeat (10) @(posedge pclk);
            n0 = nfs;
            apb(1, OFS_CMD, 1);
            lreq <= !f[0];
            repeat (10) @(posedge pclk);
            `CHK("edge", n0 + 1, nfs)
            lreq <= f[0];
            repeat (5) @(posedge pclk);
            lreq <= !f[0];
            repeat (8) @(posedge pclk);
            apb(0, OFS_STAT, 0);
            `CHK("ovr", 1'b1, q[STAT_OVR])
            `CHK("ovr drop", n0 + 1, nfs)
            `CHK("ovt pulse", f + 1, novt)
            apb(1, OFS_STAT, 32'h08);
            apb(0, OFS_STAT, 0);
            `CHK("ovr clr", 1'b0, q[STAT_OVR])
            repeat (40) @(posedge pclk);
        end
        lreq <= 0;
        apb(1, OFS_CTRL, 32'h2B);
        repeat (10) @(posedge pclk);
        apb(1, OFS_CMD, 1);
        lreq <= 1;
        repeat (7) @(posedge pclk);
        lreq <= 0;
        repeat (15) @(posedge pclk);
        `CHK("width", 7, elen)
        apb(1, OFS_CTRL, 32'h105);
        apb(1, OFS_CMD, 1);
        repeat (5) @(posedge pclk);
        apb(0, OFS_STAT, 0);
        `CHK("ast wait", 3'h1, q[2:0])
        n0 = nfs;
        ast <= 1;
        @(posedge pclk);
        ast <= 0;
        wfs(n0 + 1);
        `CHK("ast go", n0 + 1, nfs)
        apb(1, OFS_CMD, 2);
        test_done();
    end
endmodule

`default_nettype wire
